// File: hw/iic_host.sv
`timescale 1ns/1ps
// Summary of operation
// - BALE stays high for the entire DMA cycle
// - host extends a command while IOCHRDY is held low
// - interrupt priority 9,10,11,12,13,15,3,4,5,6,7, nine highest
// - low IOCHCK reported as a card error
// - IOR low requests an I/O read; card drives data
// - IOW low requests an I/O write; card takes data
// - SMEMR/SMEMW only for memory below one megabyte
// - MEMR/MEMW low for any memory access
// - DMA channels 0-3 move bytes, 5-7 move words
// - DMA priority 0,1,2,3,5,6,7, zero highest
// - each DMA grant uses its own active-low acknowledge
// - AEN high while DMA owns address, low for CPU
// - REFRESH marks refresh cycles; a bus master may start one
// - TC pulses when a DMA count reaches terminal
// - SBHE asserted when SD8-SD15 carry valid data
// - MEMCS16/IOCS16 low makes a 16-bit one-wait-state cycle
// - 0WS low ends the cycle with no extra waits
// - RSTDRV high in reset or low voltage, else low
// - BUSCLK generated independently of the processor clock
module iic_host
  import iic_pkg::*;
#(
  parameter int BUSCLK_DIV = BUSCLK_HALF
) (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        power_low_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic        req_mem_in,
  input  wire logic        req_wide_in,
  input  wire logic [23:0] req_addr_in,
  input  wire logic [15:0] req_wdata_in,
  output logic             req_ready_out,
  output logic             resp_valid_out,
  output logic [15:0]      resp_rdata_out,
  output logic             resp_wide_out,
  input  wire logic        refresh_req_in,
  input  wire logic [7:0]  drq_in,
  input  wire logic [23:0] dma_addr_in,
  input  wire logic        dma_write_in,
  input  wire logic        dma_last_in,
  output logic [2:0]       dma_chan_out,
  output logic             dma_done_out,
  output logic [7:0]       dack_n_out,
  output logic             tc_out,
  output logic             aen_out,
  output logic             bale_out,
  output logic [19:0]      sa_out,
  output logic [23:17]     la_out,
  output logic             addr_oe_out,
  input  wire logic [15:0] sd_in,
  output logic [15:0]      sd_out,
  output logic             sd_oe_out,
  output logic             ior_n_out,
  output logic             iow_n_out,
  output logic             memr_n_out,
  output logic             memw_n_out,
  output logic             sbhe_n_out,
  output logic             cmd_oe_out,
  output logic             smemr_n_out,
  output logic             smemw_n_out,
  input  wire logic        refresh_n_in,
  output logic             refresh_n_out,
  output logic             refresh_n_oe_out,
  input  wire logic        iochrdy_in,
  input  wire logic        zws_n_in,
  input  wire logic        memcs16_n_in,
  input  wire logic        iocs16_n_in,
  input  wire logic        iochck_n_in,
  input  wire logic        master_n_in,
  input  wire logic [15:0] irq_in,
  output logic             irq_active_out,
  output logic [3:0]       irq_num_out,
  output logic             card_err_out,
  output logic             master_overtime_out,
  output logic             rstdrv_out,
  output logic             busclk_out
);

  iic_state_t        state;
  iic_kind_t         kind;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic              ref_prev;
  logic              rdy_s;
  logic              zws_s;
  logic              mcs16_s;
  logic              iocs16_s;
  logic              master_s;
  logic              ref_in_s;
  logic [CW-1:0]     cnt;
  logic [CW-1:0]     target;
  logic [CW-1:0]     master_cnt;
  logic [23:0]       addr;
  logic [15:0]       wdata;
  logic              wr;
  logic              wide;
  logic              cs16;
  logic              dma_wr;
  logic              dma_tc;
  logic              ref_own;
  logic              ref_pend;
  logic              ref_ext;
  logic [7:0]        ref_addr;
  logic [7:0]        drq_m;
  logic [2:0]        pick;
  logic              cmd_done;
  logic              low1m;
  logic [7:0]        bclk_cnt;

  // second flop only: first stage is never read elsewhere
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= {refresh_n_in, master_n_in, iochck_n_in, iocs16_n_in,
                memcs16_n_in, zws_n_in, iochrdy_in};
      sync2 <= sync1;
    end
  end

  assign rdy_s    = sync2[0];
  assign zws_s    = ~sync2[1];
  assign mcs16_s  = ~sync2[2];
  assign iocs16_s = ~sync2[3];
  assign master_s = ~sync2[5];
  assign ref_in_s = ~sync2[6];

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      card_err_out <= 1'b0;
    end else begin
      card_err_out <= ~sync2[4];
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rstdrv_out <= 1'b1;
    end else begin
      rstdrv_out <= power_low_in;
    end
  end

  // free-running divider, no phase tie to the cpu clock
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bclk_cnt   <= 8'h00;
      busclk_out <= 1'b0;
    end else if (bclk_cnt >= 8'(BUSCLK_DIV - 1)) begin
      bclk_cnt   <= 8'h00;
      busclk_out <= ~busclk_out;
    end else begin
      bclk_cnt <= bclk_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_active_out <= 1'b0;
      irq_num_out    <= 4'h0;
    end else begin
      irq_active_out <= 1'b0;
      irq_num_out    <= 4'h0;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
        if (irq_in[IRQ_ORDER[i]]) begin
          irq_active_out <= 1'b1;
          irq_num_out    <= IRQ_ORDER[i];
        end
      end
    end
  end

  // channel 4 is the cascade and never requests
  assign drq_m = drq_in & 8'hEF;

  always_comb begin
    pick = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (drq_m[i]) begin
        pick = 3'(i);
      end
    end
  end

  // pending refresh: new request wins over the clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ref_pend <= 1'b0;
    end else if (refresh_req_in) begin
      ref_pend <= 1'b1;
    end else if (state == ST_ADDR && kind == K_REF) begin
      ref_pend <= 1'b0;
    end
  end

  // falling edge of the external refresh line; own drive masked
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ref_in_s;
    end
  end
  assign ref_ext = ref_in_s & ~ref_prev & ~ref_own &
                   (state == ST_IDLE || state == ST_MASTER);

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      master_cnt          <= '0;
      master_overtime_out <= 1'b0;
    end else if (!master_s) begin
      master_cnt          <= '0;
      master_overtime_out <= 1'b0;
    end else if (master_cnt >= MASTER_MAX) begin
      master_overtime_out <= 1'b1;
    end else begin
      master_cnt <= master_cnt + 1'b1;
    end
  end

  always_comb begin
    case (kind)
      K_DMA:   target = DMA_CYC;
      K_REF:   target = REF_CYC;
      default: target = cs16 ? CMD16_CYC : CMD8_CYC;
    endcase
  end

  // ready held low stretches; 0ws cuts the waits short
  assign cmd_done = rdy_s && (cnt >= target - 1'b1 ||
                    (zws_s && cnt >= ZWS_CYC - 1'b1));

  assign req_ready_out = (state == ST_IDLE) && !ref_pend && !ref_ext &&
                         (drq_m == 8'h00) && !master_s;

  // main bus sequencer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state    <= ST_IDLE;
      kind     <= K_IO;
      cnt      <= '0;
      addr     <= 24'h000000;
      wdata    <= 16'h0000;
      wr       <= 1'b0;
      wide     <= 1'b0;
      dma_wr   <= 1'b0;
      dma_tc   <= 1'b0;
      ref_own  <= 1'b0;
      ref_addr <= REF_ADDR_RST;
      dma_chan_out <= 3'h0;
    end else begin
      case (state)
        ST_IDLE, ST_MASTER: begin
          cnt <= '0;
          if (ref_pend || ref_ext) begin
            state    <= ST_ADDR;
            kind     <= K_REF;
            ref_own  <= ~ref_ext;
            addr     <= {16'h0000, ref_addr};
            ref_addr <= ref_addr + 8'h01;
            wr       <= 1'b0;
            wide     <= 1'b0;
          end else if (master_s) begin
            state <= ST_MASTER;
          end else if (state == ST_MASTER) begin
            state <= ST_IDLE;
          end else if (drq_m != 8'h00) begin
            state        <= ST_ADDR;
            kind         <= K_DMA;
            dma_chan_out <= pick;
            addr         <= dma_addr_in;
            dma_wr       <= dma_write_in;
            dma_tc       <= dma_last_in;
            wide         <= pick[2];
          end else if (req_valid_in) begin
            state <= ST_ADDR;
            kind  <= req_mem_in ? K_MEM : K_IO;
            addr  <= req_addr_in;
            wdata <= req_wdata_in;
            wr    <= req_write_in;
            wide  <= req_wide_in;
          end
        end
        ST_ADDR: begin
          if (cnt >= ADDR_CYC - 1'b1) begin
            state <= ST_CMD;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_CMD: begin
          if (cmd_done) begin
            state <= ST_END;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_END: begin
          state   <= ST_IDLE;
          ref_own <= 1'b0;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // 16-bit width seen from the card during the cycle
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cs16 <= 1'b0;
    end else if (state == ST_IDLE) begin
      cs16 <= 1'b0;
    end else if ((kind == K_MEM && mcs16_s) ||
                 (kind == K_IO && iocs16_s)) begin
      cs16 <= 1'b1;
    end
  end

  // completion pulses and read capture
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      resp_valid_out <= 1'b0;
      resp_rdata_out <= 16'h0000;
      resp_wide_out  <= 1'b0;
      dma_done_out   <= 1'b0;
      tc_out         <= 1'b0;
    end else begin
      resp_valid_out <= 1'b0;
      dma_done_out   <= 1'b0;
      tc_out         <= 1'b0;
      if (state == ST_CMD && cmd_done) begin
        if (kind == K_IO || kind == K_MEM) begin
          resp_valid_out <= 1'b1;
          resp_wide_out  <= wide & cs16;
          resp_rdata_out <= (wide & cs16) ? sd_in : {8'h00, sd_in[7:0]};
        end
        if (kind == K_DMA) begin
          dma_done_out <= 1'b1;
          tc_out       <= dma_tc;
        end
      end
    end
  end

  // small-memory strobes only for addresses inside the first megabyte
  assign low1m = (addr[23:20] == LOW1M_TOP);

  always_comb begin
    logic busy;
    logic strobe;
    busy   = (state == ST_ADDR) || (state == ST_CMD) || (state == ST_END);
    strobe = (state == ST_CMD);
    addr_oe_out = busy;
    cmd_oe_out  = busy;
    sa_out      = addr[19:0];
    la_out      = addr[23:17];
    aen_out     = busy && kind == K_DMA;
    bale_out    = (state == ST_ADDR) || (busy && kind == K_DMA);
    sd_out      = wdata;
    sd_oe_out   = busy && wr && (kind == K_IO || kind == K_MEM);
    ior_n_out   = ~(strobe && ((kind == K_IO && !wr) ||
                               (kind == K_DMA && dma_wr)));
    iow_n_out   = ~(strobe && ((kind == K_IO && wr) ||
                               (kind == K_DMA && !dma_wr)));
    memr_n_out  = ~(strobe && ((kind == K_MEM && !wr) || kind == K_REF ||
                               (kind == K_DMA && !dma_wr)));
    memw_n_out  = ~(strobe && ((kind == K_MEM && wr) ||
                               (kind == K_DMA && dma_wr)));
    smemr_n_out = memr_n_out | ~low1m;
    smemw_n_out = memw_n_out | ~low1m;
    sbhe_n_out  = ~(busy && wide && kind != K_REF);
    dack_n_out  = 8'hFF;
    if (busy && kind == K_DMA) begin
      dack_n_out[dma_chan_out] = 1'b0;
    end
    refresh_n_out    = 1'b0;
    refresh_n_oe_out = busy && kind == K_REF && ref_own;
  end

endmodule : iic_host

// File: hw/iic_pkg.sv
package iic_pkg;

  localparam int CLK_MHZ         = 40;

  // bus phase times in ns, cycle counts derived below
  localparam int T_ADDR_NS       = 50;
  localparam int T_CMD8_NS       = 500;
  localparam int T_CMD16_NS      = 125;
  localparam int T_DMA_NS        = 250;
  localparam int T_REF_NS        = 250;
  localparam int T_ZWS_NS        = 25;
  localparam int T_MASTER_MAX_NS = 15000;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int cyc_max(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc_max

  localparam int CW              = 10;
  localparam logic [CW-1:0] ADDR_CYC   = CW'(cyc_min(T_ADDR_NS));
  localparam logic [CW-1:0] CMD8_CYC   = CW'(cyc_min(T_CMD8_NS));
  localparam logic [CW-1:0] CMD16_CYC  = CW'(cyc_min(T_CMD16_NS));
  localparam logic [CW-1:0] DMA_CYC    = CW'(cyc_min(T_DMA_NS));
  localparam logic [CW-1:0] REF_CYC    = CW'(cyc_min(T_REF_NS));
  localparam logic [CW-1:0] ZWS_CYC    = CW'(cyc_min(T_ZWS_NS));
  localparam logic [CW-1:0] MASTER_MAX = CW'(cyc_max(T_MASTER_MAX_NS));

  localparam int BUSCLK_HALF     = 2;
  localparam int SYNC_W          = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST = 7'h7F;
  localparam logic [7:0]  REF_ADDR_RST = 8'h00;
  localparam logic [3:0]  LOW1M_TOP    = 4'h0;

  // interrupt service order, highest first
  localparam int IRQ_N = 11;
  localparam logic [3:0] IRQ_ORDER [IRQ_N] = '{
    4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_END,
    ST_MASTER
  } iic_state_t;

  typedef enum {
    K_IO,
    K_MEM,
    K_DMA,
    K_REF
  } iic_kind_t;

endpackage : iic_pkg

// File: tb/iic_card.sv
`timescale 1ns/1ps
module iic_card (
  input  wire logic        clk_in,
  input  wire logic        ior_n_in,
  input  wire logic        iow_n_in,
  input  wire logic        memr_n_in,
  input  wire logic [7:0]  dack_n_in,
  input  wire logic [15:0] sd_drv_in,
  input  wire logic        sd_oe_in,
  input  wire logic [15:0] rd_val_in,
  input  wire logic [7:0]  stretch_in,
  input  wire logic        zws_in,
  input  wire logic        cs16_in,
  input  wire logic [7:0]  drq_set_in,
  output logic      [15:0] sd_bus_out,
  output logic             iochrdy_out,
  output logic             zws_n_out,
  output logic             cs16_n_out,
  output logic      [7:0]  drq_out,
  output logic      [15:0] wr_q_out
);
  logic [15:0] last    = 16'h0000;
  logic [7:0]  hold    = 8'h00;
  logic [7:0]  drq_r   = 8'h00;
  logic [7:0]  ack_d   = 8'h00;
  logic        started = 1'b0;
  logic        rd;
  logic        cmd;
  assign rd = !ior_n_in || !memr_n_in;
  assign cmd = rd || !iow_n_in;
  // released bus shows the inverse, a stale value never passes
  assign sd_bus_out = sd_oe_in ? sd_drv_in : rd ? rd_val_in : ~last;
  assign iochrdy_out = !(started && hold != 8'h00);
  assign zws_n_out = !zws_in;
  assign cs16_n_out = !cs16_in;
  // request drops only once acknowledge is over
  assign drq_out = drq_r & ~(ack_d & dack_n_in);
  always_ff @(posedge clk_in) begin
    last <= sd_bus_out;
    ack_d <= ~dack_n_in;
    drq_r <= (drq_r | drq_set_in) & ~(ack_d & dack_n_in);
    if (!iow_n_in) wr_q_out <= sd_bus_out;
    if (!cmd) begin
      started <= 1'b0;
    end else if (!started) begin
      started <= 1'b1;
      hold <= stretch_in;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end
  end
endmodule : iic_card

// File: tb/iic_host_sva.sv
`timescale 1ns/1ps
module iic_host_sva
  import iic_pkg::*;
#(
  parameter int BUSCLK_DIV = BUSCLK_HALF
) (
  input wire logic         clk_sys_in,
  input wire logic         sys_rst_in,
  input wire logic         power_low_in,
  input wire logic [15:0]  irq_in,
  input wire logic         iochck_n_in,
  input wire logic [7:0]   dack_n_out,
  input wire logic         bale_out,
  input wire logic         aen_out,
  input wire logic         ior_n_out,
  input wire logic         iow_n_out,
  input wire logic         memr_n_out,
  input wire logic         smemr_n_out,
  input wire logic         sbhe_n_out,
  input wire logic [23:17] la_out,
  input wire logic         sd_oe_out,
  input wire logic         tc_out,
  input wire logic         dma_done_out,
  input wire logic         rstdrv_out,
  input wire logic         irq_active_out,
  input wire logic [3:0]   irq_num_out,
  input wire logic         card_err_out,
  input wire logic         busclk_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  logic cpu;
  assign cpu = dack_n_out == 8'hFF;
  dma_bale_a: assert property (!cpu |-> bale_out && aen_out)
    else $error("bale or aen low in dma");
  cpu_aen_a: assert property (!ior_n_out && cpu |-> !aen_out)
    else $error("aen high in cpu cycle");
  one_dack_a: assert property ($onehot0(~dack_n_out) && dack_n_out[4])
    else $error("bad acknowledge set");
  low_meg_a: assert property (!smemr_n_out |->
    !memr_n_out && la_out[23:20] == LOW1M_TOP)
    else $error("smemr outside low meg");
  io_read_a: assert property (!ior_n_out && cpu |-> !sd_oe_out)
    else $error("host drives data on read");
  io_write_a: assert property (!iow_n_out && cpu |-> sd_oe_out)
    else $error("host not driving on write");
  tc_pulse_a: assert property (tc_out |-> dma_done_out ##1 !tc_out)
    else $error("tc not a single pulse");
  rst_drv_a: assert property (1'b1 |=> rstdrv_out == $past(power_low_in))
    else $error("rstdrv wrong");
  irq_top_a: assert property ($past(irq_in[9]) |->
    irq_active_out && irq_num_out == 4'h9)
    else $error("irq nine not served first");
  card_err_a: assert property (!iochck_n_in [*5] |-> card_err_out)
    else $error("channel check missed");
  bus_clk_a: assert property (BUSCLK_DIV == 2 && $changed(busclk_out)
    |=> $stable(busclk_out) ##1 $changed(busclk_out))
    else $error("busclk rate wrong");
  dma_wide_a: assert property (dack_n_out[7:5] != 3'h7 &&
    (!memr_n_out || !ior_n_out) |-> !sbhe_n_out)
    else $error("no sbhe on word dma");
  dma_c: cover property (!cpu);
  write_c: cover property (!iow_n_out);
  err_c: cover property (card_err_out);
endmodule : iic_host_sva

bind iic_host iic_host_sva #(.BUSCLK_DIV(BUSCLK_DIV)) u_sva (.*);

// File: tb/isa_io_channel_host_bench.sv
`timescale 1ns/1ps
module isa_io_channel_host_bench
  import iic_pkg::*;
;
  typedef struct {logic wr; logic wide; logic s; logic [19:0] a;
                  logic [15:0] v; int t, lo, hi;} iic_note_t;
  logic         clk_sys_in = 0, sys_rst_in = 1, power_low_in = 0;
  logic         req_valid_in = 0, req_write_in = 0, req_mem_in = 0;
  logic         req_wide_in = 0, refresh_req_in = 0, dma_write_in = 0;
  logic         dma_last_in = 0, iochck_n_in = 1, master_n_in = 1;
  logic         cs16 = 0, zws = 0;
  logic [23:0]  req_addr_in = 0, dma_addr_in = 0;
  logic [15:0]  req_wdata_in = 0, irq_in = 0, rd_val = 0;
  logic [15:0]  sd_in, sd_out, resp_rdata_out, wr_q, g;
  logic [7:0]   drq_in, dack_n_out, drq_set = 0, stretch = 0;
  logic [19:0]  sa_out, sa_lat = 0;
  logic         bale_q = 0, sm_seen = 0;
  logic [23:17] la_out;
  logic [4:0]   e;
  logic [3:0]   irq_num_out;
  logic [2:0]   dma_chan_out;
  logic         req_ready_out, resp_valid_out, resp_wide_out, dma_done_out;
  logic         tc_out, aen_out, bale_out, addr_oe_out, sd_oe_out, ior_n_out;
  logic         iow_n_out, memr_n_out, memw_n_out, sbhe_n_out, cmd_oe_out;
  logic         smemr_n_out, smemw_n_out, refresh_n_out, refresh_n_oe_out;
  logic         iochrdy_in, zws_n_in, memcs16_n_in, iocs16_n_in, cs16_n;
  logic         irq_active_out, card_err_out, master_overtime_out;
  logic         rstdrv_out, busclk_out, refresh_n_in;
  logic [1:0]   md [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
  logic [7:0]   st [4] = '{8'h00, 8'h00, 8'h00, 8'h1E};
  int           lo [4] = '{23, 8, 4, 33};
  int           hi [4] = '{23, 8, 4, 40};
  int           seed = 84025, cyc = 0, error_cnt = 0, checks_done = 0;
  int           i, j, k, lat;
  iic_note_t    n;
  iic_note_t    q[$];
  logic [3:0]   dq[$];
  // pull-up on the refresh line, both chip selects from one card
  assign refresh_n_in = refresh_n_oe_out ? refresh_n_out : 1'b1;
  assign memcs16_n_in = cs16_n;
  assign iocs16_n_in = cs16_n;
  iic_host u_dut (.*);
  iic_card u_card (.clk_in(clk_sys_in), .ior_n_in(ior_n_out),
    .iow_n_in(iow_n_out), .memr_n_in(memr_n_out), .dack_n_in(dack_n_out),
    .sd_drv_in(sd_out), .sd_oe_in(sd_oe_out), .rd_val_in(rd_val),
    .stretch_in(stretch), .zws_in(zws), .cs16_in(cs16),
    .drq_set_in(drq_set), .sd_bus_out(sd_in), .iochrdy_out(iochrdy_in),
    .zws_n_out(zws_n_in), .cs16_n_out(cs16_n), .drq_out(drq_in),
    .wr_q_out(wr_q));
  always #12.5 clk_sys_in = ~clk_sys_in;
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cpu(input logic w, m, wd, input logic [23:0] a, input int l, h);
    iic_note_t x;
    logic [15:0] d;
    d = 16'($random(seed));
    x.wr = w;
    x.wide = wd && cs16;
    x.v = (w ? d : rd_val) & (x.wide ? 16'hFFFF : 16'h00FF);
    x.lo = l;
    x.hi = h;
    x.a = a[19:0];
    x.s = m && !w && a[23:20] == 4'h0;
    @(posedge clk_sys_in);
    {req_valid_in, req_write_in, req_mem_in, req_wide_in} <= {1'b1, w, m, wd};
    req_addr_in <= a;
    req_wdata_in <= d;
    @(negedge clk_sys_in);
    while (req_ready_out !== 1'b1) @(negedge clk_sys_in);
    x.t = cyc;
    q.push_back(x);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
  endtask : cpu
  task automatic dma(input logic [7:0] m, input logic l);
    @(posedge clk_sys_in);
    drq_set <= m;
    dma_last_in <= l;
    dma_write_in <= 1'($random(seed));
    dma_addr_in <= 24'($random(seed));
    for (int c = 0; c < 8; c++) if (m[c]) dq.push_back({l, 3'(c)});
    @(posedge clk_sys_in);
    drq_set <= 8'h00;
    while (dq.size() != 0) @(negedge clk_sys_in);
  endtask : dma
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end
  always @(negedge clk_sys_in) begin
    if (bale_q && !bale_out) sa_lat = sa_out;
    bale_q = bale_out;
    if (smemr_n_out === 1'b0) sm_seen = 1'b1;
    if (resp_valid_out === 1'b1) begin
      n = q.pop_front();
      g = n.wr ? (n.wide ? wr_q : {8'h00, wr_q[7:0]}) : resp_rdata_out;
      chk({resp_wide_out, g}, {n.wide, n.v});
      lat = cyc - n.t;
      chk(lat, (lat >= n.lo && lat <= n.hi) ? lat : n.lo);
      chk(sa_lat, n.a);
      chk(sm_seen, n.s);
      sm_seen = 1'b0;
    end
    if (dma_done_out === 1'b1)
      chk({tc_out, dma_chan_out}, dq.pop_front());
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      {cs16, zws} <= md[i];
      stretch <= st[i];
      rd_val <= 16'($random(seed));
      repeat (4) @(posedge clk_sys_in);
      // back-to-back io read, io write, low and high memory read
      for (j = 0; j < 4; j++)
        cpu(j == 1, j > 1, cs16 | 1'($random(seed)),
          {j == 3 ? 4'h9 : 4'h0, 20'($random(seed))}, lo[i], hi[i]);
      while (q.size() != 0) @(negedge clk_sys_in);
    end
    // stretch off, or refresh and dma run long
    @(posedge clk_sys_in);
    stretch <= 8'h00;
    for (i = 0; i < 9; i++)
      if (i != 4) dma(i == 8 ? 8'h84 : 8'h01 << i, i[0]);
    @(posedge clk_sys_in);
    refresh_req_in <= 1'b1;
    @(posedge clk_sys_in);
    refresh_req_in <= 1'b0;
    k = 0;
    repeat (40) @(negedge clk_sys_in)
      k += int'(refresh_n_oe_out === 1'b1 && memr_n_out === 1'b0);
    chk(k, REF_CYC);
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_in);
      irq_in <= 16'($random(seed) & $random(seed));
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      e = 5'h00;
      for (k = IRQ_N - 1; k >= 0; k--) if (irq_in[IRQ_ORDER[k]]) e = {1'b1, IRQ_ORDER[k]};
      chk({irq_active_out, irq_active_out ? irq_num_out : 4'h0}, e);
    end
    @(posedge clk_sys_in);
    iochck_n_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk(card_err_out, 1'b1);
    iochck_n_in <= 1'b1;
    // master held past its limit on purpose
    master_n_in <= 1'b0;
    repeat (620) @(posedge clk_sys_in);
    chk(master_overtime_out, 1'b1);
    master_n_in <= 1'b1;
    power_low_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk(rstdrv_out, 1'b1);
    power_low_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk({rstdrv_out, master_overtime_out}, 2'h0);
    stop_test();
  end
endmodule : isa_io_channel_host_bench
